// *** src/cmop_port.v ***
`timescale 1ns/100ps
`include "cmop_map.vh"
module cmop_port
  (
   // clock and reset
   input  wire                      i_mclk,
   input  wire                      i_arst_n,
   // store path from the core
   input  wire                      i_req,
   input  wire                      i_write,
   input  wire [31:0]               i_addr,
   input  wire [31:0]               i_wdata,
   input  wire [3:0]                i_byte_en,
   input  wire                      i_priv,
   output wire                      o_ready,
   output reg                       o_resp_valid,
   output reg                       o_resp_err,
   output reg  [31:0]               o_rdata,
   // cache and predictor command
   output reg                       o_op_valid,
   input  wire                      i_op_ready,
   output reg  [`CMOP_OP_W-1:0]     o_op_code,
   output reg  [31:0]               o_op_addr,
   output reg  [`CMOP_LEVEL_W-1:0]  o_op_level,
   output reg  [`CMOP_IDX_W-1:0]    o_op_set,
   output reg  [`CMOP_WAY_W-1:0]    o_op_way,
   output reg                       o_op_clean,
   output reg                       o_op_inval,
   output reg                       o_op_to_coherency,
   output reg                       o_op_icache_only
   );
   // ***************************************************************
   // reset release
   // ***************************************************************
   reg  [1:0] rst_sync_q;
   wire       rst_n;
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];
   // ***************************************************************
   // state
   // ***************************************************************
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_BUSY = 2'b10;
   reg  [1:0] state_q;
   reg  [1:0] state_d;
   // ***************************************************************
   // address decode
   // ***************************************************************
   reg  [`CMOP_OP_W-1:0] dec_op;
   reg                   dec_hit;
   always @*
   begin
      dec_op  = `CMOP_OP_NONE;
      dec_hit = 1'b1;
      case (i_addr)
         `CMOP_ICACHE_INVAL_ALL_OP:           dec_op = `CMOP_OP_ICACHE_INVAL_ALL;
         `CMOP_ICACHE_INVAL_ADDR_OP:          dec_op = `CMOP_OP_ICACHE_INVAL_VA;
         `CMOP_DCACHE_INVAL_ADDR_OP:          dec_op = `CMOP_OP_DC_INVAL_VA;
         `CMOP_DCACHE_INVAL_SETWAY_OP:        dec_op = `CMOP_OP_DC_INVAL_SW;
         `CMOP_DCACHE_CLEAN_ADDR_UNIFY_OP:    dec_op = `CMOP_OP_DC_CLEAN_VA_POU;
         `CMOP_DCACHE_CLEAN_ADDR_COHERENT_OP: dec_op = `CMOP_OP_DC_CLEAN_VA_POC;
         `CMOP_DCACHE_CLEAN_SETWAY_OP:        dec_op = `CMOP_OP_DC_CLEAN_SW;
         `CMOP_DCACHE_CLEAN_INVAL_ADDR_OP:    dec_op = `CMOP_OP_DC_CLINV_VA;
         `CMOP_DCACHE_CLEAN_INVAL_SETWAY_OP:  dec_op = `CMOP_OP_DC_CLINV_SW;
         `CMOP_PREDICTOR_FLUSH_OP:            dec_op = `CMOP_OP_PREDICTOR_FLUSH;
         `CMOP_RESERVED_WORD_A,
         `CMOP_RESERVED_WORD_B,
         `CMOP_RESERVED_WORD_C:               dec_op = `CMOP_OP_NONE;
         default:                             dec_hit = 1'b0;
      endcase
   end
   // ***************************************************************
   // operand split
   // ***************************************************************
   wire [`CMOP_LEVEL_W-1:0] sw_level;
   wire [`CMOP_IDX_W-1:0]   sw_set;
   wire [`CMOP_WAY_W-1:0]   sw_way;
   wire                     sw_sbz_err;
   cmop_setway_decode u_sw
     (
      .i_word    (i_wdata),
      .o_level   (sw_level),
      .o_set     (sw_set),
      .o_way     (sw_way),
      .o_sbz_err (sw_sbz_err)
      );
   // ***************************************************************
   // acceptance
   // ***************************************************************
   // a store is held off only while a previous operation waits for the arrays
   assign o_ready = (state_q == ST_IDLE);
   wire take      = i_req & o_ready;
   wire full_word = (i_byte_en == 4'hf);
   wire is_sw     = (dec_op == `CMOP_OP_DC_INVAL_SW) | (dec_op == `CMOP_OP_DC_CLEAN_SW) |
                    (dec_op == `CMOP_OP_DC_CLINV_SW);
   // out-of-geometry set/way values at level two (upper bits set) or above are simply dropped, stray level-one bits are ignored; behaviour there is open anyway
   wire launch    = take & i_write & full_word & i_priv & dec_hit &
                    (dec_op != `CMOP_OP_NONE) & ~(is_sw & sw_sbz_err);
   wire bad       = take & (~dec_hit | ~i_priv | (i_write & ~full_word));
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (launch)
               state_d = ST_BUSY;
         end
         ST_BUSY:
         begin
            if (i_op_ready)
               state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end
   // ***************************************************************
   // command register
   // ***************************************************************
   always @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q           <= ST_IDLE;
         o_resp_valid      <= 1'b0;
         o_resp_err        <= 1'b0;
         o_rdata           <= 32'h00000000;
         o_op_valid        <= 1'b0;
         o_op_code         <= `CMOP_OP_NONE;
         o_op_addr         <= 32'h00000000;
         o_op_level        <= 3'h0;
         o_op_set          <= 12'h000;
         o_op_way          <= 4'h0;
         o_op_clean        <= 1'b0;
         o_op_inval        <= 1'b0;
         o_op_to_coherency <= 1'b0;
         o_op_icache_only  <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         o_resp_valid <= take;
         o_resp_err   <= bad;
         o_rdata      <= 32'h00000000;
         if (o_op_valid & i_op_ready)
            o_op_valid <= 1'b0;
         if (launch)
         begin
            o_op_valid <= 1'b1;
            o_op_code  <= dec_op;
            // whole word kept, no alignment imposed
            o_op_addr  <= i_wdata;
            o_op_level <= is_sw ? sw_level : 3'h0;
            o_op_set   <= is_sw ? sw_set : 12'h000;
            o_op_way   <= is_sw ? sw_way : 4'h0;
            case (dec_op)
               `CMOP_OP_ICACHE_INVAL_ALL, `CMOP_OP_PREDICTOR_FLUSH:
               begin
                  o_op_addr         <= 32'h00000000;
                  o_op_clean        <= 1'b0;
                  o_op_inval        <= 1'b1;
                  o_op_to_coherency <= 1'b0;
                  o_op_icache_only  <= (dec_op == `CMOP_OP_ICACHE_INVAL_ALL);
               end
               `CMOP_OP_ICACHE_INVAL_VA:
               begin
                  o_op_clean        <= 1'b0;
                  o_op_inval        <= 1'b1;
                  o_op_to_coherency <= 1'b0;
                  o_op_icache_only  <= 1'b1;
               end
               `CMOP_OP_DC_INVAL_VA, `CMOP_OP_DC_INVAL_SW:
               begin
                  o_op_clean        <= 1'b0;
                  o_op_inval        <= 1'b1;
                  o_op_to_coherency <= 1'b1;
                  o_op_icache_only  <= 1'b0;
               end
               `CMOP_OP_DC_CLEAN_VA_POU:
               begin
                  o_op_clean        <= 1'b1;
                  o_op_inval        <= 1'b0;
                  o_op_to_coherency <= 1'b0;
                  o_op_icache_only  <= 1'b0;
               end
               `CMOP_OP_DC_CLEAN_VA_POC, `CMOP_OP_DC_CLEAN_SW:
               begin
                  o_op_clean        <= 1'b1;
                  o_op_inval        <= 1'b0;
                  o_op_to_coherency <= 1'b1;
                  o_op_icache_only  <= 1'b0;
               end
               default:
               begin
                  o_op_clean        <= 1'b1;
                  o_op_inval        <= 1'b1;
                  o_op_to_coherency <= 1'b1;
                  o_op_icache_only  <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// *** src/cmop_map.vh ***
`ifndef CMOP_MAP_VH
`define CMOP_MAP_VH
// ***************************************************************
// operation locations, byte addresses
// ***************************************************************
`define CMOP_ICACHE_INVAL_ALL_OP          32'he000ef50
`define CMOP_RESERVED_WORD_A              32'he000ef54
`define CMOP_ICACHE_INVAL_ADDR_OP         32'he000ef58
`define CMOP_DCACHE_INVAL_ADDR_OP         32'he000ef5c
`define CMOP_DCACHE_INVAL_SETWAY_OP       32'he000ef60
`define CMOP_DCACHE_CLEAN_ADDR_UNIFY_OP   32'he000ef64
`define CMOP_DCACHE_CLEAN_ADDR_COHERENT_OP 32'he000ef68
`define CMOP_DCACHE_CLEAN_SETWAY_OP       32'he000ef6c
`define CMOP_DCACHE_CLEAN_INVAL_ADDR_OP   32'he000ef70
`define CMOP_DCACHE_CLEAN_INVAL_SETWAY_OP 32'he000ef74
`define CMOP_PREDICTOR_FLUSH_OP           32'he000ef78
`define CMOP_RESERVED_WORD_B              32'he000ef7c
`define CMOP_RESERVED_WORD_C              32'he000ef80
// ***************************************************************
// decoded operation codes
// ***************************************************************
`define CMOP_OP_W                4
`define CMOP_OP_NONE             4'h0
`define CMOP_OP_ICACHE_INVAL_ALL 4'h1
`define CMOP_OP_ICACHE_INVAL_VA  4'h2
`define CMOP_OP_DC_INVAL_VA      4'h3
`define CMOP_OP_DC_INVAL_SW      4'h4
`define CMOP_OP_DC_CLEAN_VA_POU  4'h5
`define CMOP_OP_DC_CLEAN_VA_POC  4'h6
`define CMOP_OP_DC_CLEAN_SW      4'h7
`define CMOP_OP_DC_CLINV_VA      4'h8
`define CMOP_OP_DC_CLINV_SW      4'h9
`define CMOP_OP_PREDICTOR_FLUSH  4'ha
// ***************************************************************
// set/way field layout
// ***************************************************************
`define CMOP_LEVEL_MSB     3
`define CMOP_LEVEL_LSB     1
`define CMOP_LEVEL_W       3
`define CMOP_L1_LINE_LOG2  5
`define CMOP_L1_SETS_LOG2  7
`define CMOP_L1_WAYS_LOG2  2
`define CMOP_L2_LINE_LOG2  4
`define CMOP_L2_SETS_LOG2  9
`define CMOP_L2_WAYS_LOG2  0
`define CMOP_IDX_W         12
`define CMOP_WAY_W         4
`endif

// *** src/cmop_setway_decode.v ***
`timescale 1ns/100ps
`include "cmop_map.vh"
module cmop_setway_decode
  (
   // operand
   input  wire [31:0]                i_word,
   // decoded fields
   output wire [`CMOP_LEVEL_W-1:0]   o_level,
   output reg  [`CMOP_IDX_W-1:0]     o_set,
   output reg  [`CMOP_WAY_W-1:0]     o_way,
   output reg                        o_sbz_err
   );
   // ***************************************************************
   // field split per level
   // ***************************************************************
   assign o_level = i_word[`CMOP_LEVEL_MSB:`CMOP_LEVEL_LSB];
   always @*
   begin
      o_set     = {`CMOP_IDX_W{1'b0}};
      o_way     = {`CMOP_WAY_W{1'b0}};
      o_sbz_err = 1'b0;
      case (o_level)
         3'h0:
         begin
            // set starts at bit L, way in the top A bits
            o_set = {5'h00, i_word[`CMOP_L1_LINE_LOG2+`CMOP_L1_SETS_LOG2-1:
                                   `CMOP_L1_LINE_LOG2]};
            o_way = {2'h0, i_word[31:32-`CMOP_L1_WAYS_LOG2]};
         end
         3'h1:
         begin
            // line length 16: set sits right above level, no gap
            o_set = {3'h0, i_word[`CMOP_L2_LINE_LOG2+`CMOP_L2_SETS_LOG2-1:
                                  `CMOP_L2_LINE_LOG2]};
            // direct mapped: no way field, upper bits must be zero
            o_sbz_err = |i_word[31:`CMOP_L2_LINE_LOG2+`CMOP_L2_SETS_LOG2];
         end
         default:
         begin
            o_sbz_err = 1'b1;
         end
      endcase
   end
endmodule

// *** bench/cmop_port_monitor.sv ***
`timescale 1ns/100ps
`include "cmop_map.vh"
module cmop_port_monitor
  (
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_arst_n,
   // store path
   input  wire logic                  i_req,
   input  wire logic                  i_write,
   input  wire logic [31:0]           i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_byte_en,
   input  wire logic                  i_priv,
   input  wire logic                  o_ready,
   input  wire logic                  o_resp_valid,
   input  wire logic                  o_resp_err,
   input  wire logic [31:0]           o_rdata,
   // command side
   input  wire logic                  o_op_valid,
   input  wire logic                  i_op_ready,
   input  wire logic [`CMOP_OP_W-1:0] o_op_code,
   input  wire logic [31:0]           o_op_addr,
   input  wire logic                  o_op_clean,
   input  wire logic                  o_op_inval,
   input  wire logic                  o_op_to_coherency,
   input  wire logic                  o_op_icache_only
   );
   // ****
   // helpers: a taken request, and a full privileged write
   // ****
   wire take = i_req && o_ready;
   wire go   = take && i_write && i_priv && i_byte_en == 4'hf;
   wire rsvd = i_addr == `CMOP_RESERVED_WORD_A || i_addr == `CMOP_RESERVED_WORD_B ||
               i_addr == `CMOP_RESERVED_WORD_C;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   a_take_answer: assert property (take |=> o_resp_valid)
      else $error("no response after a taken request");
   a_no_stray: assert property (o_resp_valid |-> $past(take))
      else $error("response without a request");
   a_read_quiet: assert property (take && !i_write |=> !o_op_valid && o_rdata == 32'h0)
      else $error("read launched an operation or returned data");
   a_unpriv_refused: assert property (take && !i_priv |=> o_resp_err && !o_op_valid)
      else $error("unprivileged access not refused");
   a_partial_refused: assert property (take && i_write && i_byte_en != 4'hf
      |=> o_resp_err && !o_op_valid)
      else $error("partial write not refused");
   a_op_holds: assert property (o_op_valid && !i_op_ready
      |=> o_op_valid && $stable(o_op_code) && $stable(o_op_addr))
      else $error("command dropped or changed while stalled");
   a_flush_launch: assert property (go && i_addr == `CMOP_PREDICTOR_FLUSH_OP
      |=> o_op_valid && o_op_code == `CMOP_OP_PREDICTOR_FLUSH)
      else $error("predictor flush not launched");
   a_inval_attr: assert property (o_op_valid && (o_op_code == `CMOP_OP_DC_INVAL_VA ||
      o_op_code == `CMOP_OP_DC_INVAL_SW) |-> !o_op_clean && o_op_inval && o_op_to_coherency)
      else $error("invalidate op carries wrong attributes");
   a_clean_unify: assert property (o_op_valid && o_op_code == `CMOP_OP_DC_CLEAN_VA_POU
      |-> o_op_clean && !o_op_inval && !o_op_to_coherency)
      else $error("clean to unification carries wrong attributes");
   a_clean_coherent: assert property (o_op_valid && (o_op_code == `CMOP_OP_DC_CLEAN_VA_POC ||
      o_op_code == `CMOP_OP_DC_CLEAN_SW) |-> o_op_clean && !o_op_inval && o_op_to_coherency)
      else $error("clean to coherency carries wrong attributes");
   a_clinv_attr: assert property (o_op_valid && (o_op_code == `CMOP_OP_DC_CLINV_VA ||
      o_op_code == `CMOP_OP_DC_CLINV_SW) |-> o_op_clean && o_op_inval && o_op_to_coherency)
      else $error("clean and invalidate carries wrong attributes");
   a_rsvd_no_op: assert property (go && rsvd |=> !o_op_valid && !o_resp_err)
      else $error("reserved word had an effect");
   a_addr_carried: assert property (go && i_addr == `CMOP_DCACHE_INVAL_ADDR_OP
      |=> o_op_code == `CMOP_OP_DC_INVAL_VA && o_op_addr == $past(i_wdata))
      else $error("address operand not carried");
   a_icache_only: assert property (o_op_valid && (o_op_code == `CMOP_OP_ICACHE_INVAL_ALL ||
      o_op_code == `CMOP_OP_ICACHE_INVAL_VA) |-> o_op_icache_only)
      else $error("instruction op not limited to instruction cache");
   c_stall: cover property (go ##1 o_op_valid && !i_op_ready);
   c_unpriv: cover property (take && !i_priv);
   c_rsvd: cover property (go && rsvd);
endmodule
bind cmop_port cmop_port_monitor i_mon (.i_mclk, .i_arst_n, .i_req, .i_write, .i_addr,
   .i_wdata, .i_byte_en, .i_priv, .o_ready, .o_resp_valid, .o_resp_err, .o_rdata,
   .o_op_valid, .i_op_ready, .o_op_code, .o_op_addr, .o_op_clean, .o_op_inval,
   .o_op_to_coherency, .o_op_icache_only);

// *** bench/cmop_array_model.sv ***
`timescale 1ns/100ps
module cmop_array_model
  (
   // clock and reset
   input  wire i_mclk,
   input  wire i_arst_n,
   // stall control and acceptance
   input  wire i_slow,
   output reg  o_op_ready
   );
   // ****
   // accept at once, or stall at random so held commands get exercised
   // ****
   always @(posedge i_mclk or negedge i_arst_n)
      if (!i_arst_n)
         o_op_ready <= 1'b0;
      else
         o_op_ready <= i_slow ? ($urandom % 2) == 1 : 1'b1;
endmodule

// *** bench/cmop_port_bench.sv ***
`timescale 1ns/100ps
`include "cmop_map.vh"
module cmop_port_bench;
   reg                   i_mclk, i_arst_n, i_req, i_write, i_priv, slow;
   reg  [31:0]           i_addr, i_wdata, w;
   reg  [3:0]            i_byte_en;
   wire                  o_ready, o_resp_valid, o_resp_err, o_op_valid, i_op_ready;
   wire [31:0]           o_rdata, o_op_addr;
   wire [`CMOP_OP_W-1:0] o_op_code;
   wire [2:0]            o_op_level;
   wire [11:0]           o_op_set;
   wire [3:0]            o_op_way;
   integer               bad_count, checks, k, p;
   reg  [56:0]           qe[$], qm[$], e, m, g;
   // masks: address ops skip set/way, set/way ops skip address, refusals only status
   localparam [56:0] M_AD = {38'h3fffffffff, 19'h0};
   localparam [56:0] M_SW = {6'h3f, 32'h0, 19'h7ffff};
   localparam [56:0] M_NO = {2'b11, 55'h0};
   localparam [56:0] ERR  = {2'b10, 55'h0};
   cmop_port i_dut (.i_mclk, .i_arst_n, .i_req, .i_write, .i_addr, .i_wdata, .i_byte_en,
      .i_priv, .o_ready, .o_resp_valid, .o_resp_err, .o_rdata, .o_op_valid, .i_op_ready,
      .o_op_code, .o_op_addr, .o_op_level, .o_op_set, .o_op_way, .o_op_clean(),
      .o_op_inval(), .o_op_to_coherency(), .o_op_icache_only());
   cmop_array_model i_arr (.i_mclk, .i_arst_n, .i_slow(slow), .o_op_ready(i_op_ready));
   initial
   begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   task test_done;
   begin
      if (qe.size() != 0) bad_count = bad_count + 1;
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   end
   endtask
   // ****
   // one access, held until taken; request stays up so calls chain back to back
   // ****
   task acc(input [31:0] a, d, input [3:0] be, input pv, wr, input [56:0] ex, mk);
      integer n;
   begin
      qe.push_back(ex);
      qm.push_back(mk);
      i_req <= 1'b1; i_addr <= a; i_wdata <= d; i_byte_en <= be; i_priv <= pv; i_write <= wr;
      n = 0;
      @(negedge i_mclk);
      while (o_ready !== 1'b1 && n < 100)
      begin
         n = n + 1;
         @(negedge i_mclk);
      end
      if (n == 100) bad_count = bad_count + 1;
      @(posedge i_mclk);
   end
   endtask
   // ****
   // watcher: oldest note against each response, mid-cycle when settled
   // ****
   always @(negedge i_mclk)
      if (o_resp_valid === 1'b1)
      begin
         e = qe.pop_front();
         m = qm.pop_front();
         g = {o_resp_err, o_op_valid, o_op_code, o_op_addr, o_op_level, o_op_set, o_op_way};
         checks = checks + 1;
         if (((g ^ e) & m) !== 57'h0)
         begin
            bad_count = bad_count + 1;
            $display("unexpected response: expected %h seen %h", e & m, g & m);
         end
      end
   initial
   begin
      #100000;
      bad_count = bad_count + 1;
      test_done;
   end
   initial
   begin
      i_arst_n = 1'b0; i_req = 1'b0; i_write = 1'b0; i_priv = 1'b0; slow = 1'b0;
      i_addr = 32'h0; i_wdata = 32'h0; i_byte_en = 4'h0; bad_count = 0; checks = 0;
      w = $urandom(17697);
      repeat (16) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      // every operation, prompt then stalled array; set/way at level one then two
      for (p = 0; p < 4; p = p + 1)
      begin
         slow <= p[0];
         for (k = 0; k < 11; k = k + 1)
            if (k != 1)
            begin
               w = $urandom;
               if (k == 4 || k == 7 || k == 9)
               begin
                  if (p < 2)
                  begin
                     w[29:12] = 18'h0; w[4:1] = 4'h0;
                     e = {2'b01, k[3:0], 32'h0, 3'd0, 5'h0, w[11:5], 2'b00, w[31:30]};
                  end
                  else
                  begin
                     w[31:13] = 19'h0; w[3:1] = 3'd1;
                     e = {2'b01, k[3:0], 32'h0, 3'd1, 3'h0, w[12:4], 4'h0};
                  end
                  acc(32'he000ef50 + 4 * k, w, 4'hf, 1, 1, e, M_SW);
               end
               else
                  acc(32'he000ef50 + 4 * k, w, 4'hf, 1, 1, {2'b01, k ? k[3:0] : 4'h1,
                     (k == 0 || k == 10) ? 32'h0 : w, 19'h0}, M_AD);
            end
      end
      acc(`CMOP_RESERVED_WORD_A, $urandom, 4'hf, 1, 1, 57'h0, M_NO);
      acc(`CMOP_RESERVED_WORD_B, $urandom, 4'hf, 1, 1, 57'h0, M_NO);
      acc(`CMOP_RESERVED_WORD_C, $urandom, 4'hf, 1, 1, 57'h0, M_NO);
      // address loop stepped by the 32-byte data line size
      w = $urandom;
      for (k = 0; k < 4; k = k + 1)
         acc(`CMOP_DCACHE_INVAL_ADDR_OP, w + 32 * k, 4'hf, 1, 1,
            {2'b01, 4'h3, w + 32 * k, 19'h0}, M_AD);
      acc(`CMOP_PREDICTOR_FLUSH_OP, $urandom, 4'hf, 0, 1, ERR, M_NO);
      acc(`CMOP_DCACHE_INVAL_ADDR_OP, $urandom, 4'h3, 1, 1, ERR, M_NO);
      acc(`CMOP_DCACHE_INVAL_ADDR_OP, $urandom, 4'hf, 1, 0, 57'h0, {2'b01, 55'h0});
      acc(32'he000ef84, $urandom, 4'hf, 1, 1, ERR, M_NO);
      acc(`CMOP_DCACHE_INVAL_SETWAY_OP, 32'h4, 4'hf, 1, 1, 57'h0, M_NO);
      acc(`CMOP_DCACHE_CLEAN_SETWAY_OP, 32'h2002, 4'hf, 1, 1, 57'h0, M_NO);
      i_req <= 1'b0;
      repeat (10) @(posedge i_mclk);
      test_done;
   end
endmodule
